//--- dmsc_board_model.sv
// Board-side model: drives the state, rate and correction pins and the
// measured reference. Assumes the bench sets the want_* requests.
`timescale 1ns/100ps
module dmsc_board_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic [1:0] want_pick,
  input wire logic [1:0] want_rate,
  input wire logic want_hold,
  input wire logic want_quick,
  input wire logic want_clear,
  input wire logic want_present,
  input wire logic signed [31:0] want_ppb,
  input wire logic signed [31:0] want_phase,
  // Board pins
  output logic [1:0] pick,
  output logic [1:0] rate,
  output logic hold_en,
  output logic quick,
  output logic clear_n,
  output logic present,
  output logic signed [31:0] ppb,
  output logic signed [31:0] phase
);
  logic [5:0] clr_cnt_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pick <= 2'b10;
    end else begin
      pick <= want_pick;
    end
  end
  // Rate pins follow the request only while reset is held
  always_ff @(posedge clock) begin
    if (!rst_n) rate <= want_rate;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clr_cnt_r <= 6'h00;
    end else if (want_clear && clr_cnt_r == 6'h00) begin
      clr_cnt_r <= 6'h1e;
    end else if (clr_cnt_r != 6'h00) begin
      clr_cnt_r <= clr_cnt_r - 6'h01;
    end
  end
  always_ff @(posedge clock) begin
    clear_n <= (clr_cnt_r == 6'h00);
    hold_en <= want_hold;
    quick <= want_quick;
    present <= want_present;
    phase <= want_phase;
    // A lost reference leaves a word that keeps toggling, not a value
    ppb <= want_present ? want_ppb : ~ppb;
  end
endmodule // dmsc_board_model

//--- dmsc_defs.svh
// Constants for the DPLL mode and state controller.
// Included by the package and the design; definitions only.
`ifndef DMSC_DEFS_SVH
`define DMSC_DEFS_SVH
`define DMSC_CLK_NS 10
`define DMSC_FRAME_NS 125000
`define DMSC_FRAME_CYC (`DMSC_FRAME_NS / `DMSC_CLK_NS)
`define DMSC_PULSE_NS 122
`define DMSC_PULSE_CYC ((`DMSC_PULSE_NS + `DMSC_CLK_NS - 1) / `DMSC_CLK_NS)
`define DMSC_SNAP_MS 30
`define DMSC_SNAP_FRAMES (`DMSC_SNAP_MS * 8)
`define DMSC_MON_S 2
`define DMSC_MON_FRAMES (`DMSC_MON_S * 8000)
`define DMSC_FAST_MS 500
`define DMSC_FAST_FRAMES (`DMSC_FAST_MS * 8)
`define DMSC_SLOW_S 30
`define DMSC_SLOW_FRAMES (`DMSC_SLOW_S * 8000)
`define DMSC_OFFSET_PPM 12
`define DMSC_CAPTURE_PPM 130
`define DMSC_SLOPE_PS 5000
`define DMSC_CLR_NS 300
`define DMSC_CLR_CYC ((`DMSC_CLR_NS + `DMSC_CLK_NS - 1) / `DMSC_CLK_NS)
`define DMSC_ADDR_CTRL 32'h0000_0000
`define DMSC_ADDR_STAT 32'h0000_0004
`define DMSC_ADDR_FREQ 32'h0000_0008
`define DMSC_ADDR_PHASE 32'h0000_000c
`define DMSC_ADDR_ERR 32'h0000_0010
`define DMSC_CTRL_RST 32'h0000_0000
`endif

//--- dmsc_pkg.sv
// Types shared by the DPLL mode and state controller.
// Needs dmsc_defs.svh on the include path.
`include "dmsc_defs.svh"
package dmsc_pkg;
  typedef enum logic [1:0] {
    DMSC_ST_FREERUN = 2'b00,
    DMSC_ST_NORMAL = 2'b01,
    DMSC_ST_AUTO_HOLD = 2'b10,
    DMSC_ST_HOLDOVER = 2'b11
  } dmsc_state_t;
  typedef enum logic [1:0] {
    DMSC_PICK_NORMAL = 2'b00,
    DMSC_PICK_HOLDOVER = 2'b01,
    DMSC_PICK_FREERUN = 2'b10,
    DMSC_PICK_RESERVED = 2'b11
  } dmsc_pick_t;
  typedef enum logic [1:0] {
    DMSC_RATE_19M44 = 2'b00,
    DMSC_RATE_8K = 2'b01,
    DMSC_RATE_1M544 = 2'b10,
    DMSC_RATE_2M048 = 2'b11
  } dmsc_rate_t;
  typedef struct packed {
    logic normal;
    logic holdover;
    logic freerun;
    logic locked;
  } dmsc_status_t;
endpackage

//--- dmsc_top.sv
// DPLL mode and state controller: operating state, holdover snapshots,
// reference monitor and phase-transient correction control.
// Assumes all pins are synchronous to clock (master oscillator domain);
// the reference arrives as a measured frequency word and a presence flag.
//
// How it works
// [R1] State changes are applied only on the rising edge of frame_pulse_8k.
// [R2] State-pick pins hi:lo decode 00 Normal, 01 Holdover, 10 Freerun.
// [R3] After reset the board drives state-pick to 10 or 00 only.
// [R4] Normal drops to auto-holdover when the reference is invalid.
// [R5] Auto-holdover returns to Normal once the reference is valid again.
// [R6] Every state change disables correction except hold-to-Normal moves.
// [R7] Hold-to-Normal moves take correction enable from phase_hold_enable.
// [R8] Normal status output is high exactly while in Normal.
// [R9] Holdover status output is high while in either holdover state.
// [R10] Freerun status output is high exactly while in Freerun.
// [R11] quick_acquire_enable selects a faster acquisition submode in Normal.
// [R12] In Normal after reset, lock is declared within thirty seconds.
// [R13] Locked Normal stores the frequency word every 30 ms, alternating.
// [R14] Entering holdover uses the snapshot taken 30 to 60 ms earlier.
// [R15] Freerun ignores the reference and uses the master oscillator only.
// [R16] Rate-pick pins hi:lo decode 19.44M, 8k, 1.544M, 2.048M.
// [R17] The rate setting is taken only through reset.
// [R18] ref_offset_alarm is high beyond 12 ppm, refreshed every 2 seconds.
// [R19] Loss of reference or offset beyond capture range is invalid.
// [R20] With correction on, phase difference is stored and carried forward.
// [R21] phase_store_clear_n low for 300 ns clears the stored difference.
// [R22] With correction off, phase realigns at most 5 ns per frame; quick acquire before lock passes phase_diff unlimited.
// [R23] Board should keep correction off for brief holdovers.
// [R24] Reserved state-pick code 11 keeps the current state.
`timescale 1ns/100ps
`include "dmsc_defs.svh"
module dmsc_top #(
  parameter int FRAME_CYC = `DMSC_FRAME_CYC,
  parameter int SNAP_FRAMES = `DMSC_SNAP_FRAMES,
  parameter int MON_FRAMES = `DMSC_MON_FRAMES,
  parameter int FAST_FRAMES = `DMSC_FAST_FRAMES,
  parameter int SLOW_FRAMES = `DMSC_SLOW_FRAMES,
  parameter int FW = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Board control pins
  input wire logic op_state_pick_hi,
  input wire logic op_state_pick_lo,
  input wire logic ref_rate_pick_hi,
  input wire logic ref_rate_pick_lo,
  input wire logic phase_hold_enable,
  input wire logic quick_acquire_enable,
  input wire logic phase_store_clear_n,
  // Reference measurement
  input wire logic ref_present,
  input wire logic signed [FW-1:0] ref_offset_ppb,
  input wire logic signed [FW-1:0] phase_diff,
  // Outputs
  output logic frame_pulse_8k,
  output dmsc_pkg::dmsc_status_t status,
  output logic ref_offset_alarm,
  output logic phase_transient_correction,
  output logic [FW-1:0] dco_freq_word,
  output logic signed [FW-1:0] phase_step,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import dmsc_pkg::*;

  localparam logic signed [FW-1:0] OFFSET_LIM = FW'(`DMSC_OFFSET_PPM * 1000);
  localparam logic signed [FW-1:0] CAPT_LIM = FW'(`DMSC_CAPTURE_PPM * 1000);
  localparam logic signed [FW-1:0] SLOPE = FW'(`DMSC_SLOPE_PS);

  dmsc_state_t state_r, state_nxt;
  dmsc_rate_t rate_r;
  logic rate_taken_r;
  logic [31:0] frame_cnt_r;
  logic frame_edge;
  logic [31:0] snap_cnt_r, mon_cnt_r, lock_cnt_r;
  logic [FW-1:0] slot_r [2];
  logic slot_sel_r;
  logic [31:0] clr_cnt_r;
  logic signed [FW-1:0] phase_store_r;
  logic [FW-1:0] hold_word_r;
  logic ref_valid;
  logic ref_off;
  logic locked_r;
  logic [31:0] ctrl_r;
  logic [31:0] err_cnt_r;
  logic dp_act_r, dp_wr_r;
  logic [4:0] dp_addr_r;

  // Frame pulse from the master oscillator: 13 cycles (130 ns) high each 125 us
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_r <= 32'h0;
      frame_pulse_8k <= 1'b0;
    end else begin
      frame_cnt_r <= (frame_cnt_r == 32'(FRAME_CYC - 1)) ? 32'h0 :
                     frame_cnt_r + 32'h1;
      frame_pulse_8k <= (frame_cnt_r < 32'(`DMSC_PULSE_CYC));
    end
  end
  // Frame edge is the last cycle before the pulse output goes high
  assign frame_edge = (frame_cnt_r == 32'h0); // see [R1]

  // Rate pins are caught once after reset release only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_taken_r <= 1'b0;
      rate_r <= DMSC_RATE_19M44;
    end else if (!rate_taken_r) begin
      rate_taken_r <= 1'b1; // see [R17]
      rate_r <= dmsc_rate_t'({ref_rate_pick_hi, ref_rate_pick_lo}); // see [R16]
    end
  end

  // Offset wider than capture range or no reference at all is invalid
  assign ref_valid = ref_present && (ref_offset_ppb <= CAPT_LIM) &&
                     (ref_offset_ppb >= -CAPT_LIM); // see [R19]
  assign ref_off = !ref_present || (ref_offset_ppb > OFFSET_LIM) ||
                   (ref_offset_ppb < -OFFSET_LIM);

  always_comb begin
    state_nxt = state_r;
    unique case (dmsc_pick_t'({op_state_pick_hi, op_state_pick_lo})) // see [R2]
      DMSC_PICK_NORMAL: begin
        if (state_r == DMSC_ST_NORMAL && !ref_valid)
          state_nxt = DMSC_ST_AUTO_HOLD; // see [R4]
        else if (state_r == DMSC_ST_AUTO_HOLD && !ref_valid)
          state_nxt = DMSC_ST_AUTO_HOLD;
        else
          state_nxt = DMSC_ST_NORMAL; // see [R5]
      end
      DMSC_PICK_HOLDOVER: state_nxt = DMSC_ST_HOLDOVER;
      DMSC_PICK_FREERUN: state_nxt = DMSC_ST_FREERUN;
      DMSC_PICK_RESERVED: state_nxt = state_r; // see [R24]
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) state_r <= DMSC_ST_FREERUN;
    else if (frame_edge) state_r <= state_nxt; // see [R1]
  end

  // Correction enable follows the kind of state change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_transient_correction <= 1'b0;
    end else if (frame_edge && state_nxt != state_r) begin
      if (state_nxt == DMSC_ST_NORMAL && (state_r == DMSC_ST_HOLDOVER ||
          state_r == DMSC_ST_AUTO_HOLD))
        phase_transient_correction <= phase_hold_enable; // see [R7]
      else
        phase_transient_correction <= 1'b0; // see [R6]
    end
  end

  // Lock timer: quick acquire shortens it, Normal reset restarts it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_r <= 32'h0;
      locked_r <= 1'b0;
    end else if (state_r != DMSC_ST_NORMAL) begin
      lock_cnt_r <= 32'h0;
      locked_r <= 1'b0;
    end else if (frame_edge && !locked_r) begin
      lock_cnt_r <= lock_cnt_r + 32'h1;
      if (lock_cnt_r + 32'h1 >= 32'(quick_acquire_enable ?
          FAST_FRAMES : SLOW_FRAMES)) // see [R11] [R12]
        locked_r <= 1'b1;
    end
  end

  // Snapshots every 30 ms into alternating slots while locked
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      snap_cnt_r <= 32'h0;
      slot_sel_r <= 1'b0;
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else if (!(locked_r && state_r == DMSC_ST_NORMAL)) begin
      snap_cnt_r <= 32'h0;
    end else if (frame_edge) begin
      if (snap_cnt_r == 32'(SNAP_FRAMES - 1)) begin
        snap_cnt_r <= 32'h0;
        slot_r[slot_sel_r] <= FW'(ref_offset_ppb); // see [R13]
        slot_sel_r <= ~slot_sel_r;
      end else begin
        snap_cnt_r <= snap_cnt_r + 32'h1;
      end
    end
  end

  // The older slot is the one next to be written: 30 to 60 ms old
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_word_r <= '0;
    end else if (frame_edge && (state_nxt == DMSC_ST_HOLDOVER ||
                 state_nxt == DMSC_ST_AUTO_HOLD) &&
                 state_r == DMSC_ST_NORMAL) begin
      hold_word_r <= slot_r[slot_sel_r]; // see [R14]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) dco_freq_word <= '0;
    else begin
      unique case (state_r)
        DMSC_ST_FREERUN: dco_freq_word <= '0; // see [R15]
        DMSC_ST_NORMAL: dco_freq_word <= FW'(ref_offset_ppb);
        DMSC_ST_AUTO_HOLD, DMSC_ST_HOLDOVER: dco_freq_word <= hold_word_r;
      endcase
    end
  end

  // Offset alarm refreshed once per 2 s window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mon_cnt_r <= 32'h0;
      ref_offset_alarm <= 1'b0;
    end else if (frame_edge) begin
      if (mon_cnt_r == 32'(MON_FRAMES - 1)) begin
        mon_cnt_r <= 32'h0;
        ref_offset_alarm <= ref_off; // see [R18]
      end else begin
        mon_cnt_r <= mon_cnt_r + 32'h1;
      end
    end
  end

  // Clear pulse shorter than 300 ns is ignored as a glitch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) clr_cnt_r <= 32'h0;
    else if (phase_store_clear_n) clr_cnt_r <= 32'h0;
    else if (clr_cnt_r < 32'(`DMSC_CLR_CYC)) clr_cnt_r <= clr_cnt_r + 32'h1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_store_r <= '0;
    end else if (clr_cnt_r == 32'(`DMSC_CLR_CYC)) begin
      phase_store_r <= '0; // see [R21]
    end else if (frame_edge && state_nxt == DMSC_ST_NORMAL &&
                 (state_r == DMSC_ST_HOLDOVER ||
                 state_r == DMSC_ST_AUTO_HOLD) && phase_hold_enable) begin
      phase_store_r <= phase_diff; // see [R20]
    end
  end

  // Phase step per frame: offset by stored difference, else slope-limited unless quick acquire is still unlocked
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_step <= '0;
    end else if (state_r != DMSC_ST_NORMAL) begin
      phase_step <= '0;
    end else if (phase_transient_correction) begin
      phase_step <= phase_diff - phase_store_r; // see [R20]
    end else if (quick_acquire_enable && !locked_r) begin
      phase_step <= phase_diff;
    end else if (phase_diff > SLOPE) begin
      phase_step <= SLOPE; // see [R22]
    end else if (phase_diff < -SLOPE) begin
      phase_step <= -SLOPE;
    end else begin
      phase_step <= phase_diff;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    // Reset state is Freerun, so its flag starts high
    if (!rst_n) status <= 4'b0010;
    else begin
      status.normal <= (state_nxt == DMSC_ST_NORMAL) && frame_edge ||
                       (state_r == DMSC_ST_NORMAL) && !frame_edge; // see [R8]
      status.holdover <= frame_edge ?
        (state_nxt == DMSC_ST_HOLDOVER || state_nxt == DMSC_ST_AUTO_HOLD) :
        (state_r == DMSC_ST_HOLDOVER || state_r == DMSC_ST_AUTO_HOLD); // see [R9]
      status.freerun <= frame_edge ? (state_nxt == DMSC_ST_FREERUN) :
                        (state_r == DMSC_ST_FREERUN); // see [R10]
      status.locked <= locked_r;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dp_act_r <= 1'b0;
      dp_wr_r <= 1'b0;
      dp_addr_r <= 5'h0;
    end else if (hready) begin
      dp_act_r <= hsel && htrans[1] && (haddr[31:5] == 27'h0);
      dp_wr_r <= hwrite;
      dp_addr_r <= haddr[4:0];
    end
  end

  // Scratch control word; board pins remain the mode source
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ctrl_r <= `DMSC_CTRL_RST;
    else if (dp_act_r && dp_wr_r && {27'h0, dp_addr_r} == `DMSC_ADDR_CTRL)
      ctrl_r <= hwdata;
  end

  // Invalid-reference frame counter; a write clears it, a hit wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) err_cnt_r <= 32'h0;
    else if (frame_edge && !ref_valid && state_r != DMSC_ST_FREERUN)
      err_cnt_r <= err_cnt_r + 32'h1;
    else if (dp_act_r && dp_wr_r && {27'h0, dp_addr_r} == `DMSC_ADDR_ERR)
      err_cnt_r <= 32'h0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) hrdata <= 32'h0;
    else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr)
        `DMSC_ADDR_CTRL: hrdata <= ctrl_r;
        `DMSC_ADDR_STAT: hrdata <= {24'h0, rate_r, state_r, status};
        `DMSC_ADDR_FREQ: hrdata <= 32'(hold_word_r);
        `DMSC_ADDR_PHASE: hrdata <= 32'(phase_store_r);
        `DMSC_ADDR_ERR: hrdata <= err_cnt_r;
        default: hrdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // State moves only at a frame edge
  a_state_on_frame: assert property (@(posedge clock) disable iff (!rst_n)
    !frame_edge |=> $stable(state_r)) else $error("state moved off frame"); // see [R1]
  a_auto_hold_entry: assert property (@(posedge clock) disable iff (!rst_n)
    frame_edge && state_r == DMSC_ST_NORMAL && !ref_valid |=>
    state_r == DMSC_ST_AUTO_HOLD) else $error("no auto holdover"); // see [R4]
  a_auto_hold_exit: assert property (@(posedge clock) disable iff (!rst_n)
    frame_edge && state_r == DMSC_ST_AUTO_HOLD && ref_valid &&
    {op_state_pick_hi, op_state_pick_lo} == 2'b00 |=>
    state_r == DMSC_ST_NORMAL) else $error("no return to normal"); // see [R5]
  a_reserved_keep: assert property (@(posedge clock) disable iff (!rst_n)
    frame_edge && {op_state_pick_hi, op_state_pick_lo} == 2'b11 |=>
    $stable(state_r)) else $error("reserved code moved state"); // see [R24]
  a_corr_off_move: assert property (@(posedge clock) disable iff (!rst_n)
    frame_edge && state_nxt != state_r && state_nxt != DMSC_ST_NORMAL |=>
    !phase_transient_correction) else $error("correction left on"); // see [R6]
  a_corr_pin_back: assert property (@(posedge clock) disable iff (!rst_n)
    frame_edge && state_r == DMSC_ST_HOLDOVER && state_nxt == DMSC_ST_NORMAL
    |=> phase_transient_correction == $past(phase_hold_enable))
    else $error("correction ignores pin"); // see [R7]
  a_normal_flag: assert property (@(posedge clock) disable iff (!rst_n)
    status.normal == (state_r == DMSC_ST_NORMAL))
    else $error("normal flag wrong"); // see [R8]
  a_hold_flag: assert property (@(posedge clock) disable iff (!rst_n)
    status.holdover == (state_r == DMSC_ST_HOLDOVER ||
    state_r == DMSC_ST_AUTO_HOLD)) else $error("holdover flag wrong"); // see [R9]
  a_free_flag: assert property (@(posedge clock) disable iff (!rst_n)
    status.freerun == (state_r == DMSC_ST_FREERUN))
    else $error("freerun flag wrong"); // see [R10]
  a_slope_limit: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == DMSC_ST_NORMAL && $past(state_r) == DMSC_ST_NORMAL &&
    !phase_transient_correction && locked_r ##1 1'b1 |->
    phase_step <= SLOPE && phase_step >= -SLOPE)
    else $error("phase slope exceeded"); // see [R22]
  a_freerun_word: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == DMSC_ST_FREERUN ##1 state_r == DMSC_ST_FREERUN |->
    dco_freq_word == '0) else $error("freerun uses reference"); // see [R15]
endmodule // dmsc_top

//--- dpll_mode_state_control_tb_top.sv
// Testbench for the DPLL mode and state controller.
// Assumes dmsc_pkg, dmsc_top and dmsc_board_model are compiled first.
`timescale 1ns/100ps
module dpll_mode_state_control_tb_top;
  import dmsc_pkg::*;
  localparam int MON = 4;
  localparam int SLOW = 5;
  logic clock, rst_n, want_hold, want_quick, want_clear, want_present;
  logic [1:0] want_pick, want_rate, pick, rate, htrans;
  logic signed [31:0] want_ppb, want_phase, ppb, phase, phase_step;
  logic hold_en, quick, clear_n, present, frame_pulse_8k, alarm, corr;
  dmsc_status_t status;
  logic [31:0] dco, hrdata, haddr, hwdata, rd;
  logic hsel, hwrite, hreadyout, hresp;
  logic [2:0] hsize;
  logic [1:0] picks [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
  logic [2:0] stats [4] = '{3'b010, 3'b010, 3'b001, 3'b100};
  int errors, check_count;

  dmsc_board_model dmsc_board_model_inst (.clock(clock), .rst_n(rst_n),
    .want_pick(want_pick), .want_rate(want_rate), .want_hold(want_hold),
    .want_quick(want_quick), .want_clear(want_clear),
    .want_present(want_present), .want_ppb(want_ppb),
    .want_phase(want_phase), .pick(pick), .rate(rate), .hold_en(hold_en),
    .quick(quick), .clear_n(clear_n), .present(present), .ppb(ppb),
    .phase(phase));

  // Shortened counts keep every frame-based wait to a few hundred cycles
  dmsc_top #(.FRAME_CYC(20), .SNAP_FRAMES(3), .MON_FRAMES(MON),
    .FAST_FRAMES(2), .SLOW_FRAMES(SLOW), .FW(32)) dmsc_top_inst (
    .clock(clock), .rst_n(rst_n), .op_state_pick_hi(pick[1]),
    .op_state_pick_lo(pick[0]), .ref_rate_pick_hi(rate[1]),
    .ref_rate_pick_lo(rate[0]), .phase_hold_enable(hold_en),
    .quick_acquire_enable(quick), .phase_store_clear_n(clear_n),
    .ref_present(present), .ref_offset_ppb(ppb), .phase_diff(phase),
    .frame_pulse_8k(frame_pulse_8k), .status(status),
    .ref_offset_alarm(alarm), .phase_transient_correction(corr),
    .dco_freq_word(dco), .phase_step(phase_step), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task summarize;
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      errors++;
    end
  endtask

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Waits for the next rising edge of the frame pulse; optionally checks
  // that the operating status does not move before that edge
  task frame(input logic r1);
    logic [2:0] s0;
    logic p;
    s0 = status[3:1];
    p = frame_pulse_8k;
    forever begin
      @(posedge clock);
      #1;
      if (frame_pulse_8k === 1'b1 && p === 1'b0) break;
      if (r1) chk({29'h0, status[3:1]}, {29'h0, s0});
      p = frame_pulse_8k;
    end
  endtask

  task reset_with(input logic [1:0] r);
    @(posedge clock);
    rst_n <= 1'b0;
    want_rate <= r;
    want_pick <= 2'b10;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
  endtask

  initial begin
    errors = 0;
    check_count = 0;
    rst_n <= 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} <= '0;
    hsize <= 3'b010;
    {want_hold, want_clear, want_phase} <= '0;
    want_quick <= 1'b1;
    want_present <= 1'b1;
    want_ppb <= 32'sd1000;
    for (int r = 0; r < 4; r++) begin
      reset_with(2'(r));
      ahb(1'b0, 32'h4, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, 2'(r), 6'h02});
    end
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h0, 32'h5a5a0f0f);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h5a5a0f0f);
    ahb(1'b1, 32'h40, 32'hffffffff);
    ahb(1'b0, 32'h40, 32'h0);
    chk(rd, 32'h0);
    frame(1'b0);
    want_pick <= 2'b00;
    frame(1'b1);
    chk({29'h0, status[3:1]}, 32'h4);
    repeat (3) frame(1'b0);
    chk({31'h0, status.locked}, 32'h1);
    want_quick <= 1'b0;
    want_hold <= 1'b1;
    // Freerun to Normal must still disable correction despite the pin
    for (int i = 0; i < 4; i++) begin
      want_pick <= picks[i];
      frame(1'b1);
      chk({29'h0, status[3:1]}, {29'h0, stats[i]});
      chk({31'h0, corr}, 32'h0);
    end
    repeat (SLOW + 1) frame(1'b0);
    chk({31'h0, status.locked}, 32'h1);
    repeat (8) frame(1'b0);
    want_ppb <= 32'sd2000;
    want_hold <= 1'b0;
    frame(1'b0);
    want_pick <= 2'b01;
    frame(1'b1);
    // The frequency word follows the new state one cycle later
    @(posedge clock);
    #1;
    chk(dco, 32'd1000);
    want_pick <= 2'b00;
    frame(1'b1);
    chk({31'h0, corr}, 32'h0);
    want_phase <= 32'sd90000;
    repeat (2) frame(1'b0);
    chk(phase_step, 32'd5000);
    want_clear <= 1'b1;
    @(posedge clock);
    want_clear <= 1'b0;
    repeat (40) @(posedge clock);
    ahb(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h0);
    frame(1'b0);
    want_pick <= 2'b10;
    frame(1'b1);
    @(posedge clock);
    #1;
    chk(dco, 32'h0);
    want_pick <= 2'b00;
    want_hold <= 1'b1;
    frame(1'b1);
    // Both a lost reference and a far offset must count as invalid
    for (int i = 0; i < 2; i++) begin
      want_present <= 1'(i);
      want_ppb <= (i == 1) ? 32'sd200000 : 32'sd2000;
      frame(1'b1);
      chk({29'h0, status[3:1]}, 32'h2);
      chk({31'h0, corr}, 32'h0);
      ahb(1'b0, 32'h4, 32'h0);
      chk({30'h0, rd[5:4]}, 32'h2);
      want_present <= 1'b1;
      want_ppb <= 32'sd2000;
      frame(1'b1);
      chk({29'h0, status[3:1]}, 32'h4);
      chk({31'h0, corr}, 32'h1);
    end
    ahb(1'b0, 32'hc, 32'h0);
    chk(rd, 32'd90000);
    ahb(1'b0, 32'h10, 32'h0);
    chk({31'h0, rd !== 32'h0}, 32'h1);
    ahb(1'b1, 32'h10, 32'h0);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    want_ppb <= 32'sd12001;
    repeat (2 * MON + 1) frame(1'b0);
    chk({31'h0, alarm}, 32'h1);
    want_ppb <= 32'sd12000;
    repeat (2 * MON + 1) frame(1'b0);
    chk({31'h0, alarm}, 32'h0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    summarize();
  end
endmodule // dpll_mode_state_control_tb_top
